// ===== irc_fifo.sv
// synchronous fifo with valid/ready on both sides
module irc_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned D = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // channel
    irc_fifo_if.store ch
);
    localparam int unsigned AW = $clog2(D);

    logic [W-1:0]  mem_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          push;
    logic          pop;

    assign ch.full     = (cnt_r == (AW+1)'(D));
    assign ch.empty    = (cnt_r == '0);
    assign ch.wr_ready = !ch.full;
    assign ch.rd_valid = !ch.empty;
    assign ch.rd_data  = mem_r[rp_r];
    assign push        = ch.wr_valid && !ch.full;
    assign pop         = ch.rd_ready && !ch.empty;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= ch.wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + AW'(1);
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + AW'(1);
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule // irc_fifo

// ===== irc_fifo_if.sv
// valid/ready channel between the register slave, the fifo and the encoder
interface irc_fifo_if #(parameter int unsigned W = 8);
    logic         wr_valid;
    logic         wr_ready;
    logic [W-1:0] wr_data;
    logic         rd_valid;
    logic         rd_ready;
    logic [W-1:0] rd_data;
    logic         empty;
    logic         full;

    modport store (
        input  wr_valid, wr_data, rd_ready,
        output wr_ready, rd_valid, rd_data, empty, full
    );
    modport client (
        output wr_valid, wr_data, rd_ready,
        input  wr_ready, rd_valid, rd_data, empty, full
    );
endinterface

// ===== irc_optical_peer.sv
// optical transceiver model facing the codec's pulse pins
module irc_optical_peer (
    // clock
    input  wire logic clk,
    // optical link
    input  wire logic optical_tx_signal,
    output logic      optical_rx_in_n,
    // bench control
    input  wire logic flash_req,
    output int        flash_seen
);
    timeunit 1ns;
    timeprecision 1ns;

    logic tx_q     = 1'b0;
    int   low_left = 0;

    // ------------------------------------------------------------
    // emitter side: count light pulses
    // ------------------------------------------------------------
    initial flash_seen = 0;
    always @(posedge clk) begin
        tx_q <= optical_tx_signal;
        if (optical_tx_signal === 1'b1 && tx_q !== 1'b1) begin
            flash_seen <= flash_seen + 1;
        end
    end

    // ------------------------------------------------------------
    // detector side: twelve-cycle low pulse, idles high
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (flash_req) begin
            low_left <= 12;
        end else if (low_left > 0) begin
            low_left <= low_left - 1;
        end
    end
    assign optical_rx_in_n = (low_left == 0);
endmodule // irc_optical_peer

// ===== irc_pkg.sv
// constants and types for the infrared pulse codec
package irc_pkg;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W         = 8;
    localparam int unsigned DATA_W         = 32;
    localparam logic [7:0]  CTRL_OFS       = 8'h00;
    localparam logic [7:0]  STAT_OFS       = 8'h04;
    localparam logic [7:0]  TXD_OFS        = 8'h08;

    // ------------------------------------------------------------
    // control and status fields
    // ------------------------------------------------------------
    localparam int unsigned CTRL_W         = 7;
    localparam logic [6:0]  CTRL_RST       = 7'h00;
    localparam int unsigned CTRL_RATE_LSB  = 0;
    localparam int unsigned CTRL_CSEL_BIT  = 3;
    localparam int unsigned CTRL_FIXP_BIT  = 4;
    localparam int unsigned CTRL_SLEEP_BIT = 5;
    localparam int unsigned CTRL_TXSRC_BIT = 6;
    localparam int unsigned STAT_RX_BIT    = 0;
    localparam int unsigned STAT_TX_BIT    = 1;
    localparam int unsigned STAT_ENC_BIT   = 2;
    localparam int unsigned STAT_EMPTY_BIT = 3;
    localparam int unsigned STAT_FULL_BIT  = 4;

    // ------------------------------------------------------------
    // timing in 16x ticks and crystal cycles, frame length and fifo size
    // ------------------------------------------------------------
    localparam logic [3:0]  BIT_LAST       = 4'hf;
    localparam logic [3:0]  PULSE_ON       = 4'h7;
    localparam logic [3:0]  PULSE_OFF      = 4'ha;
    localparam logic [2:0]  MONO_CYCLES    = 3'h6;
    localparam logic [3:0]  FRAME_BITS     = 4'ha;
    localparam int unsigned FIFO_W         = 8;
    localparam int unsigned FIFO_D         = 8;

    // ------------------------------------------------------------
    // types and rate divisors
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RATE_115200 = 3'b000,
        RATE_57600  = 3'b001,
        RATE_19200  = 3'b010,
        RATE_9600   = 3'b011,
        RATE_38400  = 3'b100,
        RATE_4800   = 3'b101,
        RATE_2400   = 3'b110,
        RATE_TEST   = 3'b111
    } irc_rate_t;

    typedef enum logic {
        ENC_IDLE = 1'b0,
        ENC_SEND = 1'b1
    } irc_enc_t;

    function automatic logic [6:0] irc_div(input irc_rate_t r);
        case (r)
            RATE_115200: irc_div = 7'h02;
            RATE_57600:  irc_div = 7'h04;
            RATE_19200:  irc_div = 7'h0c;
            RATE_9600:   irc_div = 7'h18;
            RATE_38400:  irc_div = 7'h06;
            RATE_4800:   irc_div = 7'h30;
            RATE_2400:   irc_div = 7'h60;
            default:     irc_div = 7'h01;
        endcase
    endfunction

endpackage

// ===== irc_pulse_codec.sv
// infrared 3/16 pulse encoder and pulse-stretch decoder with apb control
module irc_pulse_codec (
    // clock and reset
    input  wire logic                        CLK_SYS,
    input  wire logic                        RSTN,
    // apb slave
    input  wire logic                        PSEL,
    input  wire logic                        PENABLE,
    input  wire logic                        PWRITE,
    input  wire logic [irc_pkg::ADDR_W-1:0]  PADDR,
    input  wire logic [irc_pkg::DATA_W-1:0]  PWDATA,
    output logic      [irc_pkg::DATA_W-1:0]  PRDATA,
    output logic                             PREADY,
    output logic                             PSLVERR,
    // uart side
    input  wire logic                        UART_TX_IN,
    output logic                             UART_RX_OUT,
    // optical side
    output logic                             OPTICAL_TX_OUT,
    input  wire logic                        OPTICAL_RX_IN_N,
    // clocking
    input  wire logic                        EXTERNAL_BIT_CLOCK_X16,
    output logic                             OSC_SLEEP_OUT
);
    import irc_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_r;
    irc_rate_t         rate;
    logic              csel;
    logic              fixp;
    logic              osc_sleep;
    logic              tx_src_fifo;
    logic              osc_off;
    logic [6:0]        div_cnt_r;
    logic [6:0]        div_last;
    logic              tick_int;
    logic              ext_prev_r;
    logic              ext_rise;
    logic              tick16;
    logic              osc_sleep_r;
    logic [9:0]        frm_sh_r;
    logic [3:0]        frm_bits_r;
    logic [3:0]        frm_ph_r;
    logic              tx_bit;
    logic              tx_prev_r;
    irc_enc_t          enc_st_r;
    irc_enc_t          enc_st_nxt;
    logic [3:0]        ph_r;
    logic [3:0]        ph_nxt;
    logic              mod;
    logic              mod_d_r;
    logic [2:0]        mono_cnt_r;
    logic              mono;
    logic              tx_out_r;
    logic              rxn_prev_r;
    logic              rx_fall;
    logic              str_act_r;
    logic [3:0]        str_cnt_r;
    logic              rx_out_r;
    logic              setup;
    logic              access;
    logic              sel_ctrl;
    logic              sel_stat;
    logic              sel_txd;
    logic              mapped;
    logic [DATA_W-1:0] prdata_r;
    logic [DATA_W-1:0] rd_mux;

    irc_fifo_if #(.W(FIFO_W)) fifo_ch ();

    assign rate        = irc_rate_t'(ctrl_r[CTRL_RATE_LSB +: 3]);
    assign csel        = ctrl_r[CTRL_CSEL_BIT];
    assign fixp        = ctrl_r[CTRL_FIXP_BIT];
    assign osc_sleep   = ctrl_r[CTRL_SLEEP_BIT];
    assign tx_src_fifo = ctrl_r[CTRL_TXSRC_BIT];

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    assign setup    = PSEL && !PENABLE;
    assign access   = PSEL && PENABLE;
    assign sel_ctrl = (PADDR == CTRL_OFS);
    assign sel_stat = (PADDR == STAT_OFS);
    assign sel_txd  = (PADDR == TXD_OFS);
    assign mapped   = sel_ctrl || sel_stat || sel_txd;

    // writes to the tx data word wait while the fifo is full
    assign fifo_ch.wr_valid = access && PWRITE && sel_txd;
    assign fifo_ch.wr_data  = PWDATA[FIFO_W-1:0];
    assign PREADY           = !(fifo_ch.wr_valid && !fifo_ch.wr_ready);
    assign PSLVERR          = access && !mapped;
    assign PRDATA           = prdata_r;

    always_comb begin
        rd_mux = '0;
        if (sel_ctrl) begin
            rd_mux[CTRL_W-1:0] = ctrl_r;
        end else if (sel_stat) begin
            rd_mux[STAT_RX_BIT]    = rx_out_r;
            rd_mux[STAT_TX_BIT]    = tx_out_r;
            rd_mux[STAT_ENC_BIT]   = (enc_st_r == ENC_SEND);
            rd_mux[STAT_EMPTY_BIT] = fifo_ch.empty;
            rd_mux[STAT_FULL_BIT]  = fifo_ch.full;
        end
    end

    // read data captured in the setup cycle, held through the access
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            prdata_r <= '0;
        end else if (setup && !PWRITE) begin
            prdata_r <= rd_mux;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_r <= CTRL_RST;
        end else if (access && PWRITE && sel_ctrl) begin
            ctrl_r <= PWDATA[CTRL_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // clock divider and tick source
    // ------------------------------------------------------------
    assign osc_off  = csel || osc_sleep;
    assign div_last = irc_div(rate) - 7'h01;
    assign tick_int = !osc_off && (div_cnt_r >= div_last);
    assign ext_rise = EXTERNAL_BIT_CLOCK_X16 && !ext_prev_r;
    assign tick16   = csel ? ext_rise : tick_int;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            div_cnt_r <= '0;
        end else if (osc_off || div_cnt_r >= div_last) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_r + 7'h01;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ext_prev_r  <= 1'b0;
            osc_sleep_r <= 1'b0;
        end else begin
            ext_prev_r  <= EXTERNAL_BIT_CLOCK_X16;
            osc_sleep_r <= osc_off;
        end
    end

    assign OSC_SLEEP_OUT = osc_sleep_r;

    // ------------------------------------------------------------
    // transmit source: pin or frames drained from the fifo
    // ------------------------------------------------------------
    assign fifo_ch.rd_ready = tx_src_fifo && (frm_bits_r == 4'h0) && tick16;
    assign tx_bit = !tx_src_fifo ? UART_TX_IN :
                    (frm_bits_r != 4'h0) ? frm_sh_r[0] : 1'b1;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            frm_sh_r   <= '1;
            frm_bits_r <= '0;
            frm_ph_r   <= '0;
        end else if (fifo_ch.rd_ready && fifo_ch.rd_valid) begin
            frm_sh_r   <= {1'b1, fifo_ch.rd_data, 1'b0};
            frm_bits_r <= FRAME_BITS;
            frm_ph_r   <= '0;
        end else if (tick16 && frm_bits_r != 4'h0) begin
            frm_ph_r <= frm_ph_r + 4'h1;
            if (frm_ph_r == BIT_LAST) begin
                frm_sh_r   <= {1'b1, frm_sh_r[9:1]};
                frm_bits_r <= frm_bits_r - 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // 3/16 encoder
    // ------------------------------------------------------------
    always_comb begin
        enc_st_nxt = enc_st_r;
        ph_nxt     = ph_r;
        if (tick16) begin
            case (enc_st_r)
                ENC_IDLE: begin
                    if (tx_prev_r && !tx_bit) begin
                        enc_st_nxt = ENC_SEND;
                        ph_nxt     = 4'h0;
                    end
                end
                ENC_SEND: begin
                    if (ph_r == BIT_LAST) begin
                        ph_nxt = 4'h0;
                        if (tx_bit) begin
                            enc_st_nxt = ENC_IDLE;
                        end
                    end else begin
                        ph_nxt = ph_r + 4'h1;
                    end
                end
                default: begin
                    enc_st_nxt = ENC_IDLE;
                    ph_nxt     = 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            enc_st_r  <= ENC_IDLE;
            ph_r      <= '0;
            tx_prev_r <= 1'b1;
        end else begin
            enc_st_r <= enc_st_nxt;
            ph_r     <= ph_nxt;
            if (tick16) begin
                tx_prev_r <= tx_bit;
            end
        end
    end

    // pulse centred in the bit: ticks 7, 8 and 9
    assign mod = (enc_st_r == ENC_SEND) && (ph_r >= PULSE_ON) && (ph_r < PULSE_OFF);

    // ------------------------------------------------------------
    // monoshot on the crystal clock
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            mod_d_r    <= 1'b0;
            mono_cnt_r <= '0;
        end else begin
            mod_d_r <= mod;
            if (mod && !mod_d_r) begin
                mono_cnt_r <= MONO_CYCLES;
            end else if (mono_cnt_r != 3'h0) begin
                mono_cnt_r <= mono_cnt_r - 3'h1;
            end
        end
    end

    assign mono = (mono_cnt_r != 3'h0);

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            tx_out_r <= 1'b0;
        end else begin
            tx_out_r <= fixp ? mono : mod;
        end
    end

    assign OPTICAL_TX_OUT = tx_out_r;

    // ------------------------------------------------------------
    // pulse-stretch decoder
    // ------------------------------------------------------------
    assign rx_fall = rxn_prev_r && !OPTICAL_RX_IN_N;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rxn_prev_r <= 1'b1;
            str_act_r  <= 1'b0;
            str_cnt_r  <= '0;
            rx_out_r   <= 1'b1;
        end else begin
            rxn_prev_r <= OPTICAL_RX_IN_N;
            if (rx_fall) begin
                str_act_r <= 1'b1;
                str_cnt_r <= 4'h0;
                rx_out_r  <= 1'b0;
            end else if (str_act_r && tick16) begin
                if (str_cnt_r == BIT_LAST) begin
                    str_act_r <= 1'b0;
                    rx_out_r  <= 1'b1;
                end else begin
                    str_cnt_r <= str_cnt_r + 4'h1;
                end
            end
        end
    end

    assign UART_RX_OUT = rx_out_r;

    // ------------------------------------------------------------
    // transmit fifo
    // ------------------------------------------------------------
    irc_fifo #(
        .W (FIFO_W),
        .D (FIFO_D)
    ) u_fifo (
        .clk   (CLK_SYS),
        .rst_n (RSTN),
        .ch    (fifo_ch.store)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    a_osc_power_down: assert property (
        osc_off |=> OSC_SLEEP_OUT
    ) else $error("oscillator not put to sleep");

    a_div_by_two: assert property (
        (tick_int && rate == RATE_115200) ##1 $stable(ctrl_r) |-> !tick_int
    ) else $error("divide by two ticked twice in a row");

    a_ext_source: assert property (
        (csel && !ext_rise) |-> !tick16
    ) else $error("tick without external edge");

    a_phase_on_tick: assert property (
        !tick16 |=> $stable(ph_r)
    ) else $error("bit phase moved without a tick");

    a_pulse_start: assert property (
        $rose(mod) |-> (ph_r == PULSE_ON)
    ) else $error("pulse did not start at tick seven");

    a_pulse_end: assert property (
        $fell(mod) |-> (ph_r == PULSE_OFF)
    ) else $error("pulse not three ticks long");

    a_space_chain: assert property (
        (tick16 && enc_st_r == ENC_SEND && ph_r == BIT_LAST && !tx_bit)
        |=> (enc_st_r == ENC_SEND && ph_r == 4'h0)
    ) else $error("consecutive space lost its pulse");

    a_mark_quiet: assert property (
        (enc_st_r == ENC_IDLE) |=> !tx_out_r || fixp || $past(fixp)
    ) else $error("pulse sent on a mark");

    a_rx_stretch: assert property (
        rx_fall |=> (!UART_RX_OUT && str_cnt_r == 4'h0)
    ) else $error("receive edge not stretched");

    a_rx_min_low: assert property (
        $rose(UART_RX_OUT) |-> ($past(str_cnt_r) == BIT_LAST)
    ) else $error("stretched space ended early");

    a_mono_len: assert property (
        $rose(mono) |-> mono [*6] ##1 !mono
    ) else $error("monoshot not six cycles");

    a_mono_out: assert property (
        ($rose(mono) && fixp)
        |=> OPTICAL_TX_OUT [*6] ##1 !OPTICAL_TX_OUT
    ) else $error("monoshot output length changed");

endmodule // irc_pulse_codec

// ===== test_ir_sir_pulse_codec.sv
// self-checking bench for the infrared pulse codec
module test_ir_sir_pulse_codec;
    timeunit 1ns;
    timeprecision 1ns;
    import irc_pkg::*;

    logic              clk_sys = 1'b0;
    logic              rstn    = 1'b0;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [ADDR_W-1:0] paddr   = '0;
    logic [DATA_W-1:0] pwdata  = '0;
    logic [DATA_W-1:0] prdata;
    logic [DATA_W-1:0] rd;
    logic              pready;
    logic              pslverr;
    logic              e;
    logic              uart_tx = 1'b1;
    logic              uart_rx;
    logic              opt_tx;
    logic              opt_rx_n;
    logic              ext_clk = 1'b0;
    logic              ext_run = 1'b0;
    logic              osc_sleep;
    logic              flash   = 1'b0;
    int                flashes;
    int                err_total  = 0;
    int                n_compared = 0;
    int                space_len;
    int                ext_cnt = 0;
    int                divs[8] = '{2, 4, 12, 24, 6, 48, 96, 1};

    always #25 clk_sys = ~clk_sys;

    // external 16x clock: one tick per eight system cycles
    always @(posedge clk_sys) begin
        ext_cnt <= ext_cnt + 1;
        if (ext_run && ext_cnt % 4 == 3) begin
            ext_clk <= ~ext_clk;
        end
    end

    irc_pulse_codec i_dut (
        .CLK_SYS(clk_sys), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .UART_TX_IN(uart_tx), .UART_RX_OUT(uart_rx), .OPTICAL_TX_OUT(opt_tx),
        .OPTICAL_RX_IN_N(opt_rx_n), .EXTERNAL_BIT_CLOCK_X16(ext_clk), .OSC_SLEEP_OUT(osc_sleep)
    );
    irc_optical_peer i_peer (
        .clk(clk_sys), .optical_tx_signal(opt_tx), .optical_rx_in_n(opt_rx_n),
        .flash_req(flash), .flash_seen(flashes)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 4000);
        if (n >= 4000) chk("apb ready", 1, 0);
        rd = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_lvl(input bit sel, input logic lvl, input int lim, output int n);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while ((sel ? uart_rx : opt_tx) !== lvl && n < lim);
    endtask

    task automatic space(input int c);
        space_len = c;
        @(posedge clk_sys);
        uart_tx <= 1'b0;
        fork
            begin
                repeat (space_len) @(posedge clk_sys);
                uart_tx <= 1'b1;
            end
        join_none
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        repeat (2) @(negedge clk_sys);
        chk("rx idle in reset", 1, uart_rx);
        chk("tx low in reset", 0, opt_tx);
        @(posedge clk_sys);
        rstn <= 1'b1;
        apb(0, CTRL_OFS, 0);
        chk("ctrl reset", 0, rd);
        apb(0, 8'h0c, 0);
        chk("unmapped error", 1, e);
        chk("unmapped data", 0, rd);
        $display("test reset done");
    endtask

    task automatic t_rate;
        int w;
        for (int r = 0; r < 8; r++) begin
            apb(1, CTRL_OFS, 32'(r));
            space(16 * divs[r]);
            wait_lvl(0, 1'b1, 40 * divs[r], w);
            wait_lvl(0, 1'b0, 40 * divs[r], w);
            chk("pulse width", 3 * divs[r], w);
            repeat (32 * divs[r]) @(posedge clk_sys);
        end
        $display("test rates done");
    endtask

    task automatic t_enc;
        int d;
        int w;
        int g;
        apb(1, CTRL_OFS, 0);
        space(64);
        wait_lvl(0, 1'b1, 100, d);
        chk("pulse delay ok", 1, d >= 14 && d <= 20);
        wait_lvl(0, 1'b0, 100, w);
        chk("pulse width", 6, w);
        wait_lvl(0, 1'b1, 100, g);
        chk("pulse spacing", 32, g + w);
        wait_lvl(0, 1'b0, 100, w);
        wait_lvl(0, 1'b1, 100, g);
        chk("no pulse on mark", 100, g);
        $display("test encoder done");
    endtask

    task automatic t_dec;
        int w;
        apb(1, CTRL_OFS, 1);
        @(posedge clk_sys);
        flash <= 1'b1;
        @(posedge clk_sys);
        flash <= 1'b0;
        wait_lvl(1, 1'b0, 50, w);
        wait_lvl(1, 1'b1, 200, w);
        chk("stretch is one bit", 1, w >= 59 && w <= 65);
        chk("stretch over 3/4 bit", 1, w >= 48);
        $display("test decoder done");
    endtask

    task automatic t_mono;
        int w;
        for (int r = 0; r < 3; r += 2) begin
            apb(1, CTRL_OFS, 32'h10 | 32'(r));
            space(16 * divs[r]);
            wait_lvl(0, 1'b1, 400, w);
            wait_lvl(0, 1'b0, 400, w);
            chk("monoshot width", 6, w);
            repeat (32 * divs[r]) @(posedge clk_sys);
        end
        $display("test monoshot done");
    endtask

    task automatic t_ext;
        int w;
        ext_run <= 1'b1;
        apb(1, CTRL_OFS, 32'h08);
        repeat (3) @(negedge clk_sys);
        chk("sleep with external", 1, osc_sleep);
        space(128);
        wait_lvl(0, 1'b1, 400, w);
        wait_lvl(0, 1'b0, 400, w);
        chk("external tick width", 24, w);
        repeat (200) @(posedge clk_sys);
        ext_run <= 1'b0;
        apb(1, CTRL_OFS, 32'h20);
        repeat (3) @(negedge clk_sys);
        chk("sleep bit", 1, osc_sleep);
        apb(1, CTRL_OFS, 0);
        repeat (3) @(negedge clk_sys);
        chk("oscillator on", 0, osc_sleep);
        $display("test clock source done");
    endtask

    task automatic t_fifo;
        int n0;
        int k;
        n0 = flashes;
        apb(1, CTRL_OFS, 32'h47);
        repeat (9) apb(1, TXD_OFS, 32'h55);
        apb(0, STAT_OFS, 0);
        chk("fifo full", 1, rd[STAT_FULL_BIT]);
        apb(1, TXD_OFS, 32'h55);
        k = 0;
        do begin
            apb(0, STAT_OFS, 0);
            k++;
        end while (!(rd[STAT_EMPTY_BIT] === 1'b1 && rd[STAT_ENC_BIT] === 1'b0) && k < 1000);
        chk("fifo drained", 1, k < 1000);
        // last frame may still be on the line: ten bits of sixteen ticks
        repeat (16 * 12) @(posedge clk_sys);
        chk("frame pulses", 50, flashes - n0);
        $display("test fifo done");
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        t_reset();
        t_rate();
        t_enc();
        t_dec();
        t_mono();
        t_ext();
        t_fifo();
        tally_and_finish();
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        $display("Error watchdog expected end seen hang");
        tally_and_finish();
    end
endmodule // test_ir_sir_pulse_codec
